// [logic/pmcs_mode_ctrl.v]
// power-mode and clock-source selector top
`timescale 1ns/10ps
module pmcs_mode_ctrl (
	// clock and reset
	input  wire       clk_i,
	input  wire       rst_i,
	// processor core side
	input  wire       ctrl_wr_i,
	input  wire [7:0] ctrl_wdata_i,
	input  wire       sleep_exec_i,
	input  wire       wake_i,
	input  wire [3:0] primary_osc_config_i,
	// source running indications
	input  wire       pri_running_i,
	input  wire       sec_running_i,
	input  wire       int_running_i,
	// controls and status
	output reg  [7:0] oscillator_control_reg_o,
	output reg  [1:0] active_src_o,
	output reg        cpu_clk_en_o,
	output reg        periph_clk_en_o,
	output reg  [2:0] mode_o,
	output reg  [3:0] primary_osc_type_o
);
`include "pmcs_regs.vh"
	wire       pri_ok;
	wire       sec_ok;
	wire       int_ok;
	reg  [2:0] mode_nxt;
	reg  [1:0] act_nxt;
	reg        tgt_ok;
	wire [1:0] req_src;
	wire       halt_bit;
	wire       wr_ok;
	// state bookkeeping
	reg  [2:0] run_st;
	reg  [2:0] idle_st;
	reg        in_run;
	reg        in_idle;
	reg        in_sleep;
	reg        cpu_en_nxt;
	reg        periph_en_nxt;

	pmcs_ready_filter u_pri (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.running_i (pri_running_i),
		.stable_o  (pri_ok)
	);
	pmcs_ready_filter u_sec (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.running_i (sec_running_i),
		.stable_o  (sec_ok)
	);
	pmcs_ready_filter u_int (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.running_i (int_running_i),
		.stable_o  (int_ok)
	);
	assign req_src  = oscillator_control_reg_o[`PMCS_SRC_HI:`PMCS_SRC_LO];
	assign halt_bit = oscillator_control_reg_o[`PMCS_HALT_BIT];
	// readiness of requested source; upper bit set means internal block
	always @* begin
		if (req_src[1])
			tgt_ok = int_ok;
		else if (req_src[0])
			tgt_ok = sec_ok;
		else
			tgt_ok = pri_ok;
	end
	// switch only on a whole-cycle boundary and only when target is stable
	always @* begin
		act_nxt = active_src_o;
		if (req_src != active_src_o && tgt_ok)
			act_nxt = req_src;
	end

	// write strobes are refused while the cpu clock is stopped
	assign wr_ok = ctrl_wr_i & cpu_clk_en_o;

	// run and idle codes that belong to the source active next cycle
	always @* begin
		case (act_nxt)
		`PMCS_SRC_PRI: begin
			run_st  = `PMCS_ST_PRIMARY_RUN_STATE;
			idle_st = `PMCS_ST_PRIMARY_IDLE_STATE;
		end
		`PMCS_SRC_SEC: begin
			run_st  = `PMCS_ST_SECONDARY_RUN_STATE;
			idle_st = `PMCS_ST_SECONDARY_IDLE_STATE;
		end
		default: begin
			// upper select bit set: internal block, lower bit ignored
			run_st  = `PMCS_ST_INT_RUN;
			idle_st = `PMCS_ST_INT_IDLE;
		end
		endcase
	end

	// family of the present state
	always @* begin
		in_run   = 1'b0;
		in_idle  = 1'b0;
		in_sleep = 1'b0;
		case (mode_o)
		`PMCS_ST_PRIMARY_RUN_STATE, `PMCS_ST_SECONDARY_RUN_STATE,
		`PMCS_ST_INT_RUN: begin
			in_run = 1'b1;
		end
		`PMCS_ST_PRIMARY_IDLE_STATE, `PMCS_ST_SECONDARY_IDLE_STATE,
		`PMCS_ST_INT_IDLE: begin
			in_idle = 1'b1;
		end
		`PMCS_ST_SLEEP: begin
			in_sleep = 1'b1;
		end
		default: begin
			in_run = 1'b0;
		end
		endcase
	end

	// mode sequencing; sleep requests are only taken in a run state
	always @* begin
		mode_nxt = mode_o;
		if (in_run) begin
			if (sleep_exec_i) begin
				// halt bit as stored at the sleep edge decides the mode
				if (halt_bit)
					mode_nxt = idle_st;
				else
					mode_nxt = `PMCS_ST_SLEEP;
			end else begin
				mode_nxt = run_st;
			end
		end else if (in_idle) begin
			// a pending source switch still moves the idle state along
			if (wake_i)
				mode_nxt = run_st;
			else
				mode_nxt = idle_st;
		end else if (in_sleep) begin
			if (wake_i)
				mode_nxt = run_st;
		end else begin
			// unused code: recover into the reset state
			mode_nxt = `PMCS_ST_PRIMARY_RUN_STATE;
		end
	end

	// clock enables that go with the next state
	always @* begin
		case (mode_nxt)
		`PMCS_ST_SLEEP: begin
			cpu_en_nxt    = 1'b0;
			periph_en_nxt = 1'b0;
		end
		`PMCS_ST_PRIMARY_IDLE_STATE, `PMCS_ST_SECONDARY_IDLE_STATE,
		`PMCS_ST_INT_IDLE: begin
			cpu_en_nxt    = 1'b0;
			periph_en_nxt = 1'b1;
		end
		default: begin
			cpu_en_nxt    = 1'b1;
			periph_en_nxt = 1'b1;
		end
		endcase
	end

	// stored control register
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			oscillator_control_reg_o <= `PMCS_CTRL_RST;
		end else if (wr_ok) begin
			oscillator_control_reg_o <= ctrl_wdata_i;
		end
	end

	// source and mode registers move together so they never disagree
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			active_src_o <= `PMCS_SRC_PRI;
			mode_o       <= `PMCS_ST_PRIMARY_RUN_STATE;
		end else begin
			active_src_o <= act_nxt;
			mode_o       <= mode_nxt;
		end
	end

	// clock enables, registered so the gates see clean levels
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cpu_clk_en_o    <= 1'b1;
			periph_clk_en_o <= 1'b1;
		end else begin
			cpu_clk_en_o    <= cpu_en_nxt;
			periph_clk_en_o <= periph_en_nxt;
		end
	end

	// primary oscillator type, copied from the configuration field
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			primary_osc_type_o <= 4'h0;
		end else begin
			primary_osc_type_o <= primary_osc_config_i;
		end
	end

endmodule // pmcs_mode_ctrl

// [common/pmcs_regs.vh]
// constants for the power-mode clock selector
`ifndef PMCS_REGS_VH
`define PMCS_REGS_VH
`define PMCS_HALT_BIT     7
`define PMCS_SRC_HI       1
`define PMCS_SRC_LO       0
`define PMCS_CTRL_RST     8'h00
`define PMCS_SRC_PRI      2'h0
`define PMCS_SRC_SEC      2'h1
`define PMCS_CFG_W        4
`define PMCS_SETTLE_CYC   4'h4
`define PMCS_ST_PRIMARY_RUN_STATE   3'h0
`define PMCS_ST_SECONDARY_RUN_STATE   3'h1
`define PMCS_ST_INT_RUN   3'h2
`define PMCS_ST_PRIMARY_IDLE_STATE  3'h3
`define PMCS_ST_SECONDARY_IDLE_STATE  3'h4
`define PMCS_ST_INT_IDLE  3'h5
`define PMCS_ST_SLEEP     3'h6
`endif

// [logic/pmcs_ready_filter.v]
// stability filter for one clock source running indication
`timescale 1ns/10ps
module pmcs_ready_filter (
	// clock and reset
	input  wire       clk_i,
	input  wire       rst_i,
	// source status
	input  wire       running_i,
	output reg        stable_o
);
`include "pmcs_regs.vh"
	reg  [3:0] cnt_r;
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r    <= 4'h0;
			stable_o <= 1'b0;
		end else if (!running_i) begin
			cnt_r    <= 4'h0;
			stable_o <= 1'b0;
		end else if (cnt_r != `PMCS_SETTLE_CYC) begin
			cnt_r    <= cnt_r + 4'h1;
		end else begin
			stable_o <= 1'b1;
		end
	end
endmodule // pmcs_ready_filter

// [bench/pmcs_chk.sv]
// assertions on the clock selector ports
`timescale 1ns/10ps
module pmcs_chk(
	input wire logic clk_i, rst_i, ctrl_wr_i, sleep_exec_i, int_running_i,
	input wire logic cpu_clk_en_o, periph_clk_en_o,
	input wire logic [7:0] ctrl_wdata_i, oscillator_control_reg_o,
	input wire logic [1:0] active_src_o,
	input wire logic [2:0] mode_o);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire halt = oscillator_control_reg_o[7];
	sequence s_slp; sleep_exec_i && cpu_clk_en_o; endsequence
	sequence s_rdy; int_running_i [*7]; endsequence
	AST_SLEEP: assert property (s_slp ##0 !halt
		|=> mode_o==3'h6 && !periph_clk_en_o) else $error("bad sleep");
	AST_IDLE: assert property (s_slp ##0 halt
		|=> !cpu_clk_en_o && periph_clk_en_o) else $error("bad idle");
	AST_WRITE: assert property (ctrl_wr_i && cpu_clk_en_o
		|=> oscillator_control_reg_o==$past(ctrl_wdata_i)) else $error("bad wr");
	AST_PRI: assert property (mode_o==3'h0
		|-> active_src_o==2'h0 && cpu_clk_en_o) else $error("bad pri");
	AST_SEC: assert property (mode_o==3'h1
		|-> active_src_o==2'h1 && periph_clk_en_o) else $error("bad sec");
	AST_INT: assert property (mode_o==3'h2
		|-> active_src_o[1] && cpu_clk_en_o) else $error("bad int");
	AST_SWITCH: assert property (s_rdy ##0 mode_o!=3'h6
		&& oscillator_control_reg_o[1] && !active_src_o[1]
		|-> ##[1:2] active_src_o[1]) else $error("no switch");
	AST_HOLD: assert property ($changed(active_src_o)
		&& active_src_o[1] |-> $past(int_running_i,4)) else $error("early");
endmodule // pmcs_chk
bind pmcs_mode_ctrl pmcs_chk chk_i(.*);

// [bench/pmcs_core_model.sv]
// processor core model: control writes, sleep and wake pulses
`timescale 1ns/10ps
module pmcs_core_model(input wire logic clk_i,
	output logic ctrl_wr_i, sleep_exec_i, wake_i,
	output logic [7:0] ctrl_wdata_i);
	initial {ctrl_wr_i,sleep_exec_i,wake_i,ctrl_wdata_i}=0;
	// kind 0 write, 1 sleep, 2 wake; data inverted once released
	task op(input int k, input logic [7:0] d);
		@(negedge clk_i);
		{ctrl_wr_i,sleep_exec_i,wake_i}=3'(4>>k);
		ctrl_wdata_i=d;
		@(negedge clk_i);
		{ctrl_wr_i,sleep_exec_i,wake_i}=0;
		ctrl_wdata_i=~d;
	endtask
endmodule // pmcs_core_model

// [bench/tb_top.sv]
// self-checking bench for the clock selector
`timescale 1ns/10ps
module tb_top;
	logic clk_i=0, rst_i=1, pri_running_i=1, sec_running_i=1;
	logic int_running_i=1, ctrl_wr_i, sleep_exec_i, wake_i;
	logic cpu_clk_en_o, periph_clk_en_o;
	logic [7:0] ctrl_wdata_i, oscillator_control_reg_o;
	logic [3:0] primary_osc_config_i=0, primary_osc_type_o;
	logic [2:0] mode_o;
	logic [1:0] active_src_o;
	int error_cnt=0, checked=0, k, h, n;
	wire [4:0] st = {cpu_clk_en_o,periph_clk_en_o,mode_o};
	initial forever #2.5 clk_i=~clk_i;
	pmcs_core_model core(.*);
	pmcs_mode_ctrl uut(.*);
	// enables and mode expected for halt h, select k, sleeping s
	function logic [4:0] em(int h, k, s);
		em = !s ? 5'(24+(k>1?2:k)) : h ? 5'(11+(k>1?2:k)) : 5'h06;
	endfunction
	task chk(logic [7:0] g, e);
		checked++;
		if (g!==e) begin
			error_cnt++;
			$display("unexpected %0t: got %h want %h", $time, g, e);
		end
	endtask
	task final_report;
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt==0 && checked>0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		n = $urandom(50) & 1;
		repeat(20) @(negedge clk_i);
		rst_i = 0;
		chk(st, 5'h18);
		repeat(6) @(negedge clk_i);
		for (k=3; k>=0; k--) begin
			h = (k+n)%2;
			core.op(0, {h[0],5'h00,k[1:0]});
			repeat(2) @(negedge clk_i);
			chk(oscillator_control_reg_o, {h[0],5'h00,k[1:0]});
			chk(st, em(h,k,0));
			core.op(1, 8'hFF);
			chk(st, em(h,k,1));
			core.op(0, 8'h5A);
			chk(oscillator_control_reg_o, {h[0],5'h00,k[1:0]});
			chk(st, em(h,k,1));
			core.op(2, 8'h00);
			chk(st, em(h,k,0));
		end
		sec_running_i = 0;
		core.op(0, 8'h01);
		repeat(8) @(negedge clk_i);
		chk(active_src_o, 2'h0);
		sec_running_i = 1;
		for (n=0; active_src_o!==2'h1; n++) begin
			if (n>20) begin
				error_cnt++;
				break;
			end
			@(negedge clk_i);
		end
		chk(st, 5'h19);
		primary_osc_config_i = 4'($urandom);
		repeat(2) @(negedge clk_i);
		chk(primary_osc_type_o, primary_osc_config_i);
		final_report;
	end
endmodule // tb_top
